// [pkg/cfl_pkg.sv]
// Package for the condition flag logic: classes, field layout, register map.
package cfl_pkg;

  // ==========================================================
  // Condition bit positions (bit 0 is the MSB of the byte)
  localparam int unsigned CFL_BIT_BOVF = 2;
  localparam int unsigned CFL_BIT_FALSE = 3;
  localparam int unsigned CFL_BIT_DOVF = 4;
  localparam int unsigned CFL_BIT_HIGH = 5;
  localparam int unsigned CFL_BIT_LOW = 6;
  localparam int unsigned CFL_BIT_EQUAL = 7;

  // Branch selection byte weights, bit 2 through bit 7
  localparam logic [3:0] CFL_W_BOVF = 4'h2;
  localparam logic [3:0] CFL_W_FALSE = 4'h1;
  localparam logic [3:0] CFL_W_DOVF = 4'h8;
  localparam logic [3:0] CFL_W_HIGH = 4'h4;
  localparam logic [3:0] CFL_W_LOW = 4'h2;
  localparam logic [3:0] CFL_W_EQUAL = 4'h1;
  localparam int unsigned CFL_SEL_SENSE = 0;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] CFL_OFF_FLAGS = 8'h00;
  localparam logic [7:0] CFL_OFF_CTRL = 8'h04;
  localparam logic [7:0] CFL_OFF_OPA = 8'h08;
  localparam logic [7:0] CFL_OFF_OPB = 8'h0C;
  localparam logic [7:0] CFL_OFF_BRANCH = 8'h10;
  localparam logic [7:0] CFL_OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] CFL_OFF_IRQ_MASK = 8'h18;

  localparam logic [7:0] CFL_FLAGS_RST = 8'h00;
  localparam logic [7:0] CFL_MASK_RST = 8'h00;
  localparam logic [1:0] CFL_RESP_OKAY = 2'h0;
  localparam logic [1:0] CFL_RESP_SLVERR = 2'h2;

  // Interrupt status bits
  localparam int unsigned CFL_IRQ_DONE = 0;
  localparam int unsigned CFL_IRQ_TAKEN = 1;
  localparam int unsigned CFL_IRQ_OVF = 2;

  // ==========================================================
  // Instruction classes, written to CTRL[3:0]
  typedef enum logic [3:0] {
    CFL_CLS_DEC_ARITH = 4'h1,
    CFL_CLS_CMP_LOG = 4'h2,
    CFL_CLS_SUB_LOG = 4'h3,
    CFL_CLS_ADD_LOG = 4'h4,
    CFL_CLS_EDIT = 4'h5,
    CFL_CLS_TEST_BITS = 4'h6,
    CFL_CLS_BRANCH = 4'h7
  } cfl_class_t;

  // One executed instruction as seen by the flag unit
  typedef struct packed {
    cfl_class_t cls;
    logic [15:0] opa;
    logic [15:0] opb;
    logic [7:0] sel;
  } cfl_req_t;

  // Flag update result
  typedef struct packed {
    logic [7:0] flags;
    logic taken;
    logic ovf;
  } cfl_res_t;

endpackage

// [rtl/cfl_axil.sv]
// AXI4-Lite slave front end: one write and one read at a time.
`timescale 1ns/1ps
`default_nettype none
module cfl_axil
  import cfl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);

  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // ==========================================================
  // Write path: take address and data in either order
  assign s_awready = !aw_held_q && !s_bvalid;
  assign s_wready = !w_held_q && !s_bvalid;
  assign wr_en = aw_held_q && w_held_q;
  assign wr_addr = awaddr_q;
  assign wr_data = wdata_q;
  assign wr_strb = wstrb_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= CFL_RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_wdata;
        wstrb_q <= s_wstrb;
      end
      if (wr_en) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_ok ? CFL_RESP_OKAY : CFL_RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read path
  assign s_arready = !s_rvalid;
  assign rd_addr = s_araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= CFL_RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata <= rd_ok ? rd_data : 32'h00000000;
      s_rresp <= rd_ok ? CFL_RESP_OKAY : CFL_RESP_SLVERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [rtl/cfl_eval.sv]
// Combinational evaluation of condition bits per instruction class.
`timescale 1ns/1ps
`default_nettype none
module cfl_eval
  import cfl_pkg::*;
#(
  parameter int unsigned WIDTH = 16
) (
  input wire cfl_req_t req,
  input wire logic [7:0] flags_in,
  output var cfl_res_t res
);

  initial begin
    if (WIDTH < 2 || WIDTH > 16) begin
      $error("cfl_eval: WIDTH must be 2..16");
    end
  end

  // ==========================================================
  // Operand arithmetic
  logic [WIDTH-1:0] a;
  logic [WIDTH-1:0] b;
  logic [WIDTH:0] sum;
  logic [WIDTH:0] dsum;
  assign a = req.opa[WIDTH-1:0];
  assign b = req.opb[WIDTH-1:0];
  assign sum = {1'b0, a} + {1'b0, b};
  // Signed magnitude decimal value held as two's complement here
  assign dsum = {a[WIDTH-1], a} + {b[WIDTH-1], b};

  // Bit n of the byte lives at vector index 7-n
  function automatic logic [7:0] put_result(input logic [7:0] f, input logic hi,
                                            input logic lo, input logic eq);
    logic [7:0] r;
    r = f;
    r[7-CFL_BIT_HIGH] = hi;
    r[7-CFL_BIT_LOW] = lo;
    r[7-CFL_BIT_EQUAL] = eq;
    return r;
  endfunction

  // ==========================================================
  // Branch selection
  logic [5:0] cond;
  logic [5:0] selm;
  logic present;
  logic [7:0] f;
  logic dovf;
  logic bovf;
  logic zero;
  assign cond = flags_in[5:0];
  // Selection byte bits 2..7 pick the same positions; weights are 2,1,8,4,2,1
  assign selm = req.sel[5:0];
  assign present = |(cond & selm);

  always_comb begin
    f = flags_in;
    res.taken = 1'b0;
    res.ovf = 1'b0;
    dovf = (a[WIDTH-1] == b[WIDTH-1]) && (dsum[WIDTH-1] != a[WIDTH-1]);
    bovf = sum[WIDTH];
    zero = 1'b0;
    case (req.cls)
      CFL_CLS_DEC_ARITH: begin
        zero = (dsum[WIDTH-1:0] == '0);
        f[7-CFL_BIT_DOVF] = dovf;
        f = put_result(f, !zero && !dsum[WIDTH-1], !zero && dsum[WIDTH-1], zero);
        res.ovf = dovf;
      end
      CFL_CLS_CMP_LOG: begin
        f = put_result(f, a > b, a < b, a == b);
      end
      CFL_CLS_SUB_LOG: begin
        f = put_result(f, b > a, b <= a, a == b);
      end
      CFL_CLS_ADD_LOG: begin
        zero = (sum[WIDTH-1:0] == '0);
        f[7-CFL_BIT_BOVF] = bovf;
        f = put_result(f, bovf && !zero, !bovf && !zero, zero);
        res.ovf = bovf;
      end
      CFL_CLS_EDIT: begin
        zero = (a == '0);
        f = put_result(f, !zero && !a[WIDTH-1], !zero && a[WIDTH-1], zero);
      end
      CFL_CLS_TEST_BITS: begin
        // Operand B is the mask; test true when all masked bits are one
        f[7-CFL_BIT_FALSE] = ((a & b) != b);
      end
      CFL_CLS_BRANCH: begin
        res.taken = req.sel[7-CFL_SEL_SENSE] ? present : !present;
        if (selm[7-CFL_BIT_FALSE]) begin
          f[7-CFL_BIT_FALSE] = 1'b0;
        end
        if (selm[7-CFL_BIT_DOVF]) begin
          f[7-CFL_BIT_DOVF] = 1'b0;
        end
      end
      default: begin
        f = flags_in;
      end
    endcase
    res.flags = f;
  end

endmodule
`default_nettype wire

// [rtl/cfl_top.sv]
// Condition flag unit top: register file, execution strobe, interrupts.
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Decimal arithmetic sets bit 4 on overflow and one of bits 5, 6, 7 for positive, negative, zero.
// - Logical compare sets bit 5 for op1 above op2, bit 6 for below, bit 7 for equal.
// - Logical subtract sets bit 5 for B above A, bit 6 for B at most A, bit 7 for A equal B.
// - Add logical sets bit 2 on overflow, bit 5 for carry and nonzero, bit 6 for no carry and nonzero, bit 7 for zero.
// - Edit sets bit 5 for a positive source, bit 6 for negative, bit 7 for a zero source.
// - Test bits sets bit 3 when the tested bits fail the test.
// - A branch that tests bit 3 or bit 4 clears that bit.
// - The selection byte weights bits 2 to 7 as 2, 1, 8, 4, 2, 1.
// - Selection bit 0 low branches on absence, high on presence of the selected conditions.
module cfl_top
  import cfl_pkg::*;
#(
  parameter int unsigned WIDTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic irq
);

  initial begin
    if (WIDTH < 2 || WIDTH > 16) begin
      $error("cfl_top: WIDTH must be 2..16");
    end
  end

  // ==========================================================
  // Bus front end
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  logic aw_ready_w;
  logic w_ready_w;
  logic ar_ready_w;

  cfl_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(aw_ready_w),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(w_ready_w),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(ar_ready_w),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // Ready lines are ANDed with flops that reset low and are set by the first clock after release.
  // They keep the ready lines low in the first cycle after reset and then stay high, which
  // hides a request the front end takes in that cycle; the front end gates acceptance on its own ready alone.
  logic awr_q;
  logic wr_q;
  logic arr_q;
  assign s_awready = awr_q && aw_ready_w;
  assign s_wready = wr_q && w_ready_w;
  assign s_arready = arr_q && ar_ready_w;

  // ==========================================================
  // Register state
  logic [7:0] flags_q;
  logic [3:0] cls_q;
  logic [15:0] opa_q;
  logic [15:0] opb_q;
  logic [7:0] sel_q;
  logic taken_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_mask_q;
  logic exec_pulse;
  cfl_req_t req;
  cfl_res_t res;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

  assign exec_pulse = wr_en && hit(wr_addr, CFL_OFF_CTRL) && wr_strb[0];
  assign wr_ok = hit(wr_addr, CFL_OFF_FLAGS) || hit(wr_addr, CFL_OFF_CTRL) ||
                 hit(wr_addr, CFL_OFF_OPA) || hit(wr_addr, CFL_OFF_OPB) ||
                 hit(wr_addr, CFL_OFF_BRANCH) || hit(wr_addr, CFL_OFF_IRQ_STAT) ||
                 hit(wr_addr, CFL_OFF_IRQ_MASK);

  // Execution uses the class byte being written, so one write runs it
  assign req = '{cls: cfl_class_t'(wr_data[3:0]), opa: opa_q, opb: opb_q, sel: sel_q};

  cfl_eval #(
    .WIDTH(WIDTH)
  ) u_eval (
    .req(req),
    .flags_in(flags_q),
    .res(res)
  );

  // ==========================================================
  // Ready registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awr_q <= 1'b0;
      wr_q <= 1'b0;
      arr_q <= 1'b0;
    end else begin
      awr_q <= 1'b1;
      wr_q <= 1'b1;
      arr_q <= 1'b1;
    end
  end

  // ==========================================================
  // Condition register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= CFL_FLAGS_RST;
      taken_q <= 1'b0;
      cls_q <= 4'h0;
    end else if (exec_pulse) begin
      flags_q <= res.flags;
      cls_q <= wr_data[3:0];
      if (req.cls == CFL_CLS_BRANCH) begin
        taken_q <= res.taken;
      end
    end else if (wr_en && hit(wr_addr, CFL_OFF_FLAGS) && wr_strb[0]) begin
      // Software may restore a saved condition byte; bits 0 and 1 unused
      flags_q <= {2'b00, wr_data[5:0]};
    end
  end

  // ==========================================================
  // Operands and selection byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opa_q <= 16'h0000;
      opb_q <= 16'h0000;
      sel_q <= 8'h00;
    end else if (wr_en) begin
      if (hit(wr_addr, CFL_OFF_OPA)) begin
        if (wr_strb[0]) opa_q[7:0] <= wr_data[7:0];
        if (wr_strb[1]) opa_q[15:8] <= wr_data[15:8];
      end
      if (hit(wr_addr, CFL_OFF_OPB)) begin
        if (wr_strb[0]) opb_q[7:0] <= wr_data[7:0];
        if (wr_strb[1]) opb_q[15:8] <= wr_data[15:8];
      end
      if (hit(wr_addr, CFL_OFF_BRANCH) && wr_strb[0]) begin
        sel_q <= wr_data[7:0];
      end
    end
  end

  // ==========================================================
  // Interrupts: set wins over write-one-to-clear
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  assign irq_set[CFL_IRQ_DONE] = exec_pulse;
  assign irq_set[CFL_IRQ_TAKEN] = exec_pulse && req.cls == CFL_CLS_BRANCH && res.taken;
  assign irq_set[CFL_IRQ_OVF] = exec_pulse && res.ovf;
  assign irq_clr = (wr_en && hit(wr_addr, CFL_OFF_IRQ_STAT) && wr_strb[0]) ?
                   wr_data[2:0] : 3'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= 3'h0;
      irq_mask_q <= CFL_MASK_RST[2:0];
      irq <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      if (wr_en && hit(wr_addr, CFL_OFF_IRQ_MASK) && wr_strb[0]) begin
        irq_mask_q <= wr_data[2:0];
      end
      irq <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_q);
    end
  end

  // ==========================================================
  // Read decode
  always_comb begin
    rd_ok = 1'b1;
    rd_data = 32'h00000000;
    case (rd_addr)
      CFL_OFF_FLAGS: rd_data = {24'h000000, flags_q};
      CFL_OFF_CTRL: rd_data = {23'h000000, taken_q, 4'h0, cls_q};
      CFL_OFF_OPA: rd_data = {16'h0000, opa_q};
      CFL_OFF_OPB: rd_data = {16'h0000, opb_q};
      CFL_OFF_BRANCH: rd_data = {24'h000000, sel_q};
      CFL_OFF_IRQ_STAT: rd_data = {29'h00000000, irq_stat_q};
      CFL_OFF_IRQ_MASK: rd_data = {29'h00000000, irq_mask_q};
      default: rd_ok = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// [verif/cfl_axi_master.sv]
// Sequencer side model: AXI4-Lite master issuing register transfers.
`timescale 1ns/1ps
`default_nettype none
module cfl_axi_master (
  input wire logic aclk,
  output logic [7:0] s_awaddr,
  output logic s_awvalid,
  input wire logic s_awready,
  output logic [31:0] s_wdata,
  output logic [3:0] s_wstrb,
  output logic s_wvalid,
  input wire logic s_wready,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  output logic s_bready,
  output logic [7:0] s_araddr,
  output logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0] s_rresp,
  input wire logic s_rvalid,
  output logic s_rready
);
  initial begin
    s_awaddr = 8'h00;
    s_awvalid = 1'h0;
    s_wdata = 32'h0;
    s_wstrb = 4'h0;
    s_wvalid = 1'h0;
    s_bready = 1'h0;
    s_araddr = 8'h00;
    s_arvalid = 1'h0;
    s_rready = 1'h0;
  end

  // ==========================================================
  // Transfers; no wait limit here, the bench watchdog ends hangs
  task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'h0;
    w_done = 1'h0;
    @(posedge aclk);
    s_awaddr <= a;
    s_awvalid <= 1'h1;
    s_wdata <= d;
    s_wstrb <= 4'hF;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_awready) begin
        aw_done = 1'h1;
        s_awvalid <= 1'h0;
      end
      if (!w_done && s_wready) begin
        w_done = 1'h1;
        s_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (!s_bvalid);
    r = s_bresp;
    s_bready <= 1'h0;
  endtask

  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    do @(posedge aclk); while (!s_arready);
    s_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_rvalid);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'h0;
  endtask
endmodule
`default_nettype wire

// [verif/cfl_top_asserts.sv]
// Checker for the condition flag unit bus contract and reset state.
`timescale 1ns/1ps
`default_nettype none
module cfl_top_chk
  import cfl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0] s_rresp,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // Handshake steps
  sequence s_wr_taken;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  sequence s_rd_taken;
    s_arvalid && s_arready;
  endsequence

  // ==========================================================
  // Answers and holding
  // Held address and data meet one cycle later, the response one after that
  a_write_answer: assert property (s_wr_taken |-> ##2 s_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_rd_taken |=> s_rvalid)
    else $error("read data late");
  a_bresp_holds: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped or changed");
  a_rdata_holds: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata)
    && $stable(s_rresp))
    else $error("read data dropped or changed");
  a_bvalid_clears: assert property (s_bvalid && s_bready |=> !s_bvalid)
    else $error("write response repeated");
  a_rvalid_clears: assert property (s_rvalid && s_rready |=> !s_rvalid)
    else $error("read data repeated");
  // A pending answer blocks new requests of its own kind, so one write and one read at a time
  a_write_blocked: assert property (s_bvalid |-> !s_awready && !s_wready)
    else $error("write accepted while response pending");
  a_read_blocked: assert property (s_rvalid |-> !s_arready)
    else $error("read accepted while data pending");
  a_bresp_legal: assert property (s_bvalid |-> s_bresp == CFL_RESP_OKAY
    || s_bresp == CFL_RESP_SLVERR)
    else $error("write response code unexpected");
  a_reset_quiet: assert property ($rose(aresetn) |-> !s_awready && !s_arready && !s_bvalid
    && !s_rvalid && !irq)
    else $error("outputs active at reset release");
endmodule

bind cfl_top cfl_top_chk i_cfl_top_chk (.aclk, .aresetn, .s_awvalid, .s_awready, .s_wvalid,
  .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
  .s_rvalid, .s_rready, .irq);
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the condition flag unit over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cfl_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, irq;
  int n_mismatch = 0;
  int checked = 0;
  // Class, A, B, flags before, flags after (flag byte: condition bit n at data bit 7-n)
  // Last entry is an undecoded class, which must leave the byte alone
  localparam logic [51:0] CASES [20] = '{
    52'h1000200031014, 52'h10002FFFD1012, 52'h10005FFFB1011, 52'h17FFF0001101A,
    52'h2000500031014, 52'h2000300051012, 52'h2000700071011,
    52'h3000300051014, 52'h3000500031012, 52'h3000400041013,
    52'h4000100021012, 52'h4FFFF00021034, 52'h4FFFF00011031, 52'h4000000001011,
    52'h5000500001014, 52'h5800000001012, 52'h5000000001011,
    52'h600F000300000, 52'h600F001010010, 52'h0000100021212};

  always #5 aclk = ~aclk;

  cfl_top i_cfl_top (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .irq);
  cfl_axi_master i_cfl_axi_master (.aclk, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
    .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);

  // ==========================================================
  // Shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    i_cfl_axi_master.write(a, d, r);
    check({30'h0, r}, {30'h0, CFL_RESP_OKAY});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    i_cfl_axi_master.read(a, d, r);
    check({30'h0, r}, {30'h0, CFL_RESP_OKAY});
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_reset_map();
    logic [31:0] d;
    logic [1:0] r;
    rd(CFL_OFF_FLAGS, d);
    check(d, {24'h0, CFL_FLAGS_RST});
    rd(CFL_OFF_IRQ_MASK, d);
    check(d, {24'h0, CFL_MASK_RST});
    i_cfl_axi_master.read(8'h1C, d, r);
    check({30'h0, r}, {30'h0, CFL_RESP_SLVERR});
    check(d, 32'h0);
    i_cfl_axi_master.write(8'h1C, 32'hFF, r);
    check({30'h0, r}, {30'h0, CFL_RESP_SLVERR});
    $display("test_reset_map done");
  endtask

  task automatic test_classes();
    logic [31:0] d;
    logic [3:0] cls;
    logic [15:0] a, b;
    logic [7:0] pre, exp;
    for (int i = 0; i < 20; i++) begin
      {cls, a, b, pre, exp} = CASES[i];
      wr(CFL_OFF_OPA, {16'h0, a});
      wr(CFL_OFF_OPB, {16'h0, b});
      wr(CFL_OFF_FLAGS, {24'h0, pre});
      wr(CFL_OFF_CTRL, {28'h0, cls});
      rd(CFL_OFF_FLAGS, d);
      check(d, {24'h0, exp});
      rd(CFL_OFF_CTRL, d);
      check({28'h0, d[3:0]}, {28'h0, cls});
    end
    $display("test_classes done");
  endtask

  // Each condition bit alone, flag set or clear, presence or absence mode
  task automatic test_branch();
    logic [31:0] d;
    logic [7:0] bitv;
    for (int n = 2; n < 8; n++) begin
      for (int k = 0; k < 4; k++) begin
        bitv = 8'h80 >> n;
        wr(CFL_OFF_FLAGS, {24'h0, k[1] ? bitv : 8'h00});
        wr(CFL_OFF_BRANCH, {24'h0, k[0], 7'h0} | {24'h0, bitv});
        wr(CFL_OFF_CTRL, {28'h0, CFL_CLS_BRANCH});
        rd(CFL_OFF_CTRL, d);
        check({31'h0, d[8]}, {31'h0, k[1] == k[0]});
        rd(CFL_OFF_FLAGS, d);
        check(d, (k[1] && n != 3 && n != 4) ? {24'h0, bitv} : 32'h0);
      end
    end
    $display("test_branch done");
  endtask

  task automatic test_irq();
    logic [31:0] d;
    check({31'h0, irq}, 32'h0);
    rd(CFL_OFF_IRQ_STAT, d);
    check(d, 32'h7);
    wr(CFL_OFF_IRQ_MASK, 32'h2);
    @(posedge aclk);
    #1;
    check({31'h0, irq}, 32'h1);
    wr(CFL_OFF_IRQ_STAT, 32'h2);
    @(posedge aclk);
    #1;
    check({31'h0, irq}, 32'h0);
    rd(CFL_OFF_IRQ_STAT, d);
    check(d, 32'h5);
    rd(CFL_OFF_IRQ_MASK, d);
    check(d, 32'h2);
    $display("test_irq done");
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    test_reset_map();
    test_classes();
    test_branch();
    test_irq();
    tally_and_finish();
  end

  // About 250 transfers of a few cycles each; far more than that means a hang
  initial begin
    repeat (50000) @(posedge aclk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
